// [hw/synth_serial_program_port.sv]
// Purpose: serial programming port and pin control of a fractional-N synthesizer
// Assumes: latch strobe rises only with the serial clock idle
// Notes:   register writes take effect in the system clock domain
//
// Overview of operation
// - words arrive most significant bit first
// - trailing bits pick the target register
// - data sampled on serial clock rising edge
// - strobe rise loads word into selected register
// - chip enable powers only enabled sections
// - open-drain fast-settle or general output
// - multiplexed status output, normally lock
// - modulator order programmable up to fourth
// - timeout ends fast settle and slip reduction
// - selectable divide-by-two of oscillator output
`timescale 1ns/1ps
module synth_serial_program_port
#(
  parameter int NREGS = synth_port_pkg::NUM_REGS
) (
  // system
  input  wire logic                                           clk,
  input  wire logic                                           srst,
  // serial link
  input  wire logic                                           sclk,
  input  wire logic                                           sdata,
  input  wire logic                                           latchLoadStrobe,
  // pins and loop status
  input  wire logic                                           chipEnable,
  input  wire logic                                           lockDetectRaw,
  // open-drain fast settle pin
  output logic                                                fastSettleOutput,
  output logic                                                fastSettleOe,
  // status pin
  output logic                                                lockMonitorOutput,
  // analogue controls
  output synth_port_pkg::power_t                              powerEn,
  output logic                                                div2Enable,
  output logic                    [2:0]                       modOrder,
  output logic                                                fastSettleActive,
  output logic                                                cycleSlipActive,
  output logic                    [NREGS-1:0][synth_port_pkg::DATA_W-1:0] regFile
);
  import synth_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // link clock shifter

  logic [WORD_W-1:0] shiftWord;

  serial_shifter #(
    .WIDTH (WORD_W)
  ) u_shifter (
    .sclk      (sclk),
    .sdata     (sdata),
    .shiftWord (shiftWord)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [SYNC_W-1:0] strobeSync_q;
  logic [SYNC_W-1:0] strobeSync_d;
  logic [SYNC_W-1:0] ceSync_q;
  logic [SYNC_W-1:0] ceSync_d;
  logic              strobeLast_q;
  logic              strobeLast_d;
  logic              ceLast_q;
  logic              ceLast_d;
  logic              latchEdge;
  logic              ceRise;
  logic              ceOn;

  always_comb begin
    strobeSync_d = {strobeSync_q[0], latchLoadStrobe};
    ceSync_d     = {ceSync_q[0], chipEnable};
    strobeLast_d = strobeSync_q[1];
    ceLast_d     = ceSync_q[1];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      strobeSync_q <= '0;
      ceSync_q     <= '0;
      strobeLast_q <= 1'b0;
      ceLast_q     <= 1'b0;
    end else begin
      strobeSync_q <= strobeSync_d;
      ceSync_q     <= ceSync_d;
      strobeLast_q <= strobeLast_d;
      ceLast_q     <= ceLast_d;
    end
  end

  assign latchEdge = strobeSync_q[1] & ~strobeLast_q;
  assign ceRise    = ceSync_q[1] & ~ceLast_q;
  assign ceOn      = ceSync_q[1];

  ////////////////////////////////////////////////////////////////////////////////
  // register latch

  logic [SEL_W-1:0]                  wordSel;
  logic [DATA_W-1:0]                 wordData;
  logic [NREGS-1:0][DATA_W-1:0]      regs_q;
  logic [NREGS-1:0][DATA_W-1:0]      regs_d;
  logic                              writeFirst;
  ctrl_t                             ctrl;

  assign wordSel    = shiftWord[SEL_W-1:0];
  assign wordData   = shiftWord[WORD_W-1:SEL_W];
  assign writeFirst = latchEdge && (wordSel == SEL_FIRST_CONFIG);

  always_comb begin
    regs_d = regs_q;
    if (latchEdge && (int'(wordSel) < NREGS)) begin
      regs_d[wordSel[$clog2(NREGS)-1:0]] = wordData;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      regs_q <= '{default: REG_RESET};
    end else begin
      regs_q <= regs_d;
    end
  end

  assign regFile = regs_q;
  assign ctrl    = ctrl_t'(regs_q[SEL_CONTROL[$clog2(NREGS)-1:0]]);

  ////////////////////////////////////////////////////////////////////////////////
  // power, relock, divider, modulator order

  logic relockOk_q;
  logic relockOk_d;
  logic lockOk;

  always_comb begin
    relockOk_d = relockOk_q;
    if (ceRise) begin
      relockOk_d = 1'b0;
    end
    if (writeFirst) begin
      relockOk_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      relockOk_q <= 1'b0;
    end else begin
      relockOk_q <= relockOk_d;
    end
  end

  assign lockOk     = lockDetectRaw & relockOk_q & ceOn & ceLast_q;
  assign powerEn    = ceOn ? power_t'({ctrl.outBufPwr, ctrl.vcoPwr, ctrl.pllPwr}) : '0;
  assign div2Enable = ctrl.div2En;
  assign modOrder   = (ctrl.modOrder > MOD_ORDER_MAX) ? MOD_ORDER_MAX : ctrl.modOrder;

  ////////////////////////////////////////////////////////////////////////////////
  // fast settle timeout

  settle_t    settle_q;
  settle_t    settle_d;
  logic [7:0] timer_q;
  logic [7:0] timer_d;

  always_comb begin
    settle_d = settle_q;
    timer_d  = timer_q;
    case (settle_q)
      SETTLE_IDLE: begin
        if (writeFirst && (ctrl.timeout != TIMEOUT_RESET)) begin
          settle_d = SETTLE_RUN;
          timer_d  = ctrl.timeout;
        end
      end
      SETTLE_RUN: begin
        if (writeFirst && (ctrl.timeout != TIMEOUT_RESET)) begin
          timer_d = ctrl.timeout;
        end else if (timer_q <= 8'h01) begin
          settle_d = SETTLE_IDLE;
          timer_d  = TIMEOUT_RESET;
        end else begin
          timer_d = timer_q - 8'h01;
        end
      end
      default: begin
        settle_d = SETTLE_IDLE;
        timer_d  = TIMEOUT_RESET;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      settle_q <= SETTLE_IDLE;
      timer_q  <= TIMEOUT_RESET;
    end else begin
      settle_q <= settle_d;
      timer_q  <= timer_d;
    end
  end

  assign fastSettleActive = (settle_q == SETTLE_RUN);
  assign cycleSlipActive  = fastSettleActive & ctrl.cycleSlipEn;

  ////////////////////////////////////////////////////////////////////////////////
  // output pins

  logic flPull_q;
  logic flPull_d;
  logic lockMon_q;
  logic lockMon_d;

  always_comb begin
    flPull_d = ctrl.gpoMode ? ~ctrl.gpoLevel : fastSettleActive;
    case (ctrl.lockMuxSel)
      MUX_LOCK:  lockMon_d = lockOk;
      MUX_POWER: lockMon_d = ceOn;
      MUX_LOW:   lockMon_d = 1'b0;
      MUX_HIGH:  lockMon_d = 1'b1;
      default:   lockMon_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      flPull_q  <= 1'b0;
      lockMon_q <= 1'b0;
    end else begin
      flPull_q  <= flPull_d;
      lockMon_q <= lockMon_d;
    end
  end

  assign fastSettleOutput  = 1'b0;
  assign fastSettleOe      = flPull_q;
  assign lockMonitorOutput = lockMon_q;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence sLoadFirst;
    latchEdge && (wordSel == SEL_FIRST_CONFIG);
  endsequence

  sequence sCeUpNoWrite;
    ceRise && !writeFirst;
  endsequence

  a_latch_load: assert property (@(posedge clk) disable iff (srst)
    sLoadFirst |=> (regFile[0] == $past(wordData)))
    else $error("selected register not loaded");

  a_other_keep: assert property (@(posedge clk) disable iff (srst)
    sLoadFirst |=> (regFile[1] == $past(regFile[1])))
    else $error("unaddressed register changed");

  a_sel_route: assert property (@(posedge clk) disable iff (srst)
    (latchEdge && wordSel == SEL_CONTROL) |=> $stable(regFile[0]))
    else $error("write went to wrong register");

  a_power_gate: assert property (@(posedge clk) disable iff (srst)
    !ceOn |-> (powerEn == '0))
    else $error("section powered with chip enable low");

  a_relock_hold: assert property (@(posedge clk) disable iff (srst)
    (sCeUpNoWrite ##1 (!writeFirst && ctrl.lockMuxSel == MUX_LOCK)) |=> !lockMonitorOutput)
    else $error("lock shown before first word rewritten");

  a_settle_bound: assert property (@(posedge clk) disable iff (srst)
    (fastSettleActive && !writeFirst) |-> ##[1:256] !fastSettleActive || writeFirst)
    else $error("fast settle outlived its timeout");

  a_fl_pull: assert property (@(posedge clk) disable iff (srst)
    (fastSettleActive && !ctrl.gpoMode) |=> (fastSettleOe && !fastSettleOutput))
    else $error("fast settle pin not pulled low");

  a_mod_order: assert property (@(posedge clk) disable iff (srst)
    (ctrl.modOrder > MOD_ORDER_MAX) ? (modOrder == MOD_ORDER_MAX)
                                    : (modOrder == ctrl.modOrder))
    else $error("modulator order out of range");

  a_mux_lock: assert property (@(posedge clk) disable iff (srst)
    (ctrl.lockMuxSel == MUX_LOCK) |=> (lockMonitorOutput == $past(lockOk)))
    else $error("status pin does not follow lock");

endmodule : synth_serial_program_port

// [hw/synth_port_pkg.sv]
// Purpose: shared constants and types for the synthesizer serial programming port
// Assumes: 24-bit words, trailing 4 bits select the target register
// Notes:   control word layout is given by ctrl_t
package synth_port_pkg;

  localparam int WORD_W   = 24;
  localparam int SEL_W    = 4;
  localparam int DATA_W   = WORD_W - SEL_W;
  localparam int NUM_REGS = 4;
  localparam int SYNC_W   = 2;

  // register select codes
  localparam logic [SEL_W-1:0] SEL_FIRST_CONFIG = 4'h0;
  localparam logic [SEL_W-1:0] SEL_CONTROL      = 4'h1;

  // reset values
  localparam logic [DATA_W-1:0] REG_RESET     = 20'h00000;
  localparam logic [7:0]        TIMEOUT_RESET = 8'h00;

  // modulator order limit
  localparam logic [2:0] MOD_ORDER_MAX = 3'h4;

  // lock monitor source codes
  localparam logic [1:0] MUX_LOCK  = 2'h0;
  localparam logic [1:0] MUX_POWER = 2'h1;
  localparam logic [1:0] MUX_LOW   = 2'h2;
  localparam logic [1:0] MUX_HIGH  = 2'h3;

  typedef struct packed {
    logic       cycleSlipEn;
    logic [7:0] timeout;
    logic [1:0] lockMuxSel;
    logic       gpoLevel;
    logic       gpoMode;
    logic       div2En;
    logic [2:0] modOrder;
    logic       outBufPwr;
    logic       vcoPwr;
    logic       pllPwr;
  } ctrl_t;

  typedef struct packed {
    logic outBufPwr;
    logic vcoPwr;
    logic pllPwr;
  } power_t;

  typedef enum logic {SETTLE_IDLE, SETTLE_RUN} settle_t;

endpackage : synth_port_pkg

// [hw/serial_shifter.sv]
// Purpose: serial shift register on the link clock
// Assumes: host keeps the serial clock still while the strobe is high
// Notes:   no reset; contents are data only
`timescale 1ns/1ps
module serial_shifter #(
  parameter int WIDTH = 24
) (
  // link side
  input  wire logic             sclk,
  input  wire logic             sdata,
  // word out
  output logic      [WIDTH-1:0] shiftWord
);

  logic [WIDTH-1:0] shift_q;
  logic [WIDTH-1:0] shift_d;

  always_comb begin
    shift_d = {shift_q[WIDTH-2:0], sdata};
  end

  always_ff @(posedge sclk) begin
    shift_q <= shift_d;
  end

  assign shiftWord = shift_q;

endmodule : serial_shifter

// [dv/serial_host_model.sv]
// Purpose: host model driving the three-wire programming link
// Assumes: serial clock stands low outside words
// Notes:   data line inverts after each word, as the host lets go of it
`timescale 1ns/1ps
module serial_host_model (
  // system
  input  wire logic clk,
  // serial link
  output logic      sclk,
  output logic      sdata,
  output logic      latchLoadStrobe
);
  import synth_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sclk            = 1'b0;
    sdata           = 1'b0;
    latchLoadStrobe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one word at 125 ns per bit, then the strobe pulse
  task automatic send(input logic [SEL_W-1:0] sel, input logic [DATA_W-1:0] data);
    logic [WORD_W-1:0] w;
    w = {data, sel};
    // offset keeps link edges away from system clock edges
    #3.3;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      sdata = w[i];
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
    sdata = ~sdata;
    @(negedge clk);
    latchLoadStrobe = 1'b1;
    repeat (6) @(negedge clk);
    latchLoadStrobe = 1'b0;
    repeat (4) @(negedge clk);
  endtask : send
endmodule : serial_host_model

// [dv/synth_serial_program_port_tb_top.sv]
// Purpose: self-checking bench of the synthesizer programming port
// Assumes: host model drives the link, bench drives pins at falling clk
// Notes:   control word fields follow ctrl_t
`timescale 1ns/1ps
module synth_serial_program_port_tb_top;
  import synth_port_pkg::*;

  logic                            clk           = 1'b0;
  logic                            srst          = 1'b1;
  logic                            chipEnable    = 1'b0;
  logic                            lockDetectRaw = 1'b0;
  logic                            sclk;
  logic                            sdata;
  logic                            latchLoadStrobe;
  logic                            fastSettleOutput;
  logic                            fastSettleOe;
  logic                            lockMonitorOutput;
  power_t                          powerEn;
  logic                            div2Enable;
  logic [2:0]                      modOrder;
  logic                            fastSettleActive;
  logic                            cycleSlipActive;
  logic [NUM_REGS-1:0][DATA_W-1:0] regFile;
  int                              failures      = 0;
  int                              comparisons   = 0;

  always #12.5 clk = ~clk;

  serial_host_model host (.clk(clk), .sclk(sclk), .sdata(sdata),
                          .latchLoadStrobe(latchLoadStrobe));

  synth_serial_program_port #(.NREGS(NUM_REGS)) dut (
    .clk(clk), .srst(srst), .sclk(sclk), .sdata(sdata),
    .latchLoadStrobe(latchLoadStrobe), .chipEnable(chipEnable),
    .lockDetectRaw(lockDetectRaw), .fastSettleOutput(fastSettleOutput),
    .fastSettleOe(fastSettleOe), .lockMonitorOutput(lockMonitorOutput),
    .powerEn(powerEn), .div2Enable(div2Enable), .modOrder(modOrder),
    .fastSettleActive(fastSettleActive), .cycleSlipActive(cycleSlipActive),
    .regFile(regFile));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                     input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int r = 0; r < NUM_REGS; r++) begin
      chk(regFile[r], '0, "register reset value");
    end
    host.send(4'h2, 20'hABCDE);
    chk(regFile[2], 20'hABCDE, "selected register load");
    chk(regFile[3], '0, "other register changed");
    host.send(4'h3, 20'h13579);
    chk(regFile[3], 20'h13579, "select three load");
    chk(regFile[2], 20'hABCDE, "select two disturbed");
    host.send(4'h5, 20'hFFFFF);
    chk(regFile[3], 20'h13579, "unmapped select wrote");
    chk(regFile[2], 20'hABCDE, "unmapped select wrote");
    chk(regFile[1], '0, "unmapped select hit reg one");
    chk(regFile[0], '0, "unmapped select hit reg zero");
    $display("test regs done");
  endtask : t_regs

  task automatic t_ctrl();
    host.send(SEL_CONTROL, {1'b0, 8'h00, MUX_LOW, 2'b00, 1'b1, 3'h7, 3'b101});
    chk(20'(modOrder), 20'h4, "order clamp");
    chk(20'(div2Enable), 20'h1, "divide by two");
    chk(20'(powerEn), 20'h0, "power with chip disabled");
    chipEnable = 1'b1;
    repeat (4) @(negedge clk);
    chk(20'(powerEn), 20'h5, "power with chip enabled");
    host.send(SEL_CONTROL, {1'b0, 8'h00, MUX_LOW, 2'b00, 1'b0, 3'h3, 3'b010});
    chk(20'(modOrder), 20'h3, "order three");
    chk(20'(div2Enable), 20'h0, "divide by two off");
    chk(20'(powerEn), 20'h2, "power bits follow");
    $display("test ctrl done");
  endtask : t_ctrl

  task automatic t_settle();
    int n = 0;
    int m = 0;
    int k = 0;
    host.send(SEL_CONTROL, {1'b1, 8'h05, MUX_LOCK, 2'b00, 1'b0, 3'h1, 3'b111});
    fork
      host.send(SEL_FIRST_CONFIG, 20'h00000);
      begin
        @(posedge latchLoadStrobe);
        repeat (40) begin
          @(negedge clk);
          n += int'(fastSettleActive === 1'b1);
          m += int'(cycleSlipActive === 1'b1);
          k += int'(fastSettleOe === 1'b1);
        end
      end
    join
    chk(20'(n), 20'd5, "fast settle length");
    chk(20'(m), 20'd5, "slip reduction length");
    chk(20'(k), 20'd5, "pull-down length");
    chk(20'(fastSettleOutput), 20'h0, "open-drain data");
    host.send(SEL_CONTROL, {1'b0, 8'h20, MUX_LOCK, 2'b00, 1'b0, 3'h1, 3'b111});
    host.send(SEL_FIRST_CONFIG, 20'h00000);
    chk(20'(fastSettleActive), 20'h1, "fast settle running");
    chk(20'(cycleSlipActive), 20'h0, "slip reduction off");
    chk(20'(fastSettleOe), 20'h1, "pull-down while settling");
    host.send(SEL_CONTROL, {1'b0, 8'h00, MUX_LOCK, 2'b01, 1'b0, 3'h1, 3'b111});
    chk(20'(fastSettleOe), 20'h1, "output driven low");
    host.send(SEL_CONTROL, {1'b0, 8'h00, MUX_LOCK, 2'b11, 1'b0, 3'h1, 3'b111});
    chk(20'(fastSettleOe), 20'h0, "output released");
    $display("test settle done");
  endtask : t_settle

  task automatic t_lock();
    logic [3:0] expLvl;
    expLvl = 4'b1011;
    lockDetectRaw = 1'b1;
    chipEnable = 1'b0;
    repeat (4) @(negedge clk);
    chipEnable = 1'b1;
    repeat (4) begin
      @(negedge clk);
      chk(20'(lockMonitorOutput), 20'h0, "lock before rewrite");
    end
    host.send(SEL_FIRST_CONFIG, 20'h00000);
    for (int s = 0; s < 4; s++) begin
      host.send(SEL_CONTROL, {1'b0, 8'h00, 2'(s), 2'b00, 1'b0, 3'h1, 3'b111});
      chk(20'(lockMonitorOutput), 20'(expLvl[s]), "status source");
    end
    host.send(SEL_CONTROL, {1'b0, 8'h00, MUX_LOCK, 2'b00, 1'b0, 3'h1, 3'b111});
    lockDetectRaw = 1'b0;
    repeat (3) @(negedge clk);
    chk(20'(lockMonitorOutput), 20'h0, "lock lost");
    $display("test lock done");
  endtask : t_lock

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    t_regs();
    t_ctrl();
    t_settle();
    t_lock();
    test_done();
  end

  initial begin
    #200000;
    failures++;
    test_done();
  end
endmodule : synth_serial_program_port_tb_top
